// *** logic/ipta_arbiter.sv ***
module ipta_arbiter
    import ipta_pkg::*;
#(
    parameter int ADDR_TRAP = 4
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    input  wire logic [3:0]  avsByteEnable,
    output logic [31:0]      avsReadData,
    output logic             avsWaitRequest,
    input  wire logic [53:0] srcEvent,
    input  wire logic [3:0]  cpuLevel,
    input  wire logic        inService,
    input  wire logic        instrDone,
    input  wire logic [7:0]  trapEvent,
    input  wire logic        trapVectorInvalid,
    input  wire logic        trapAck,
    input  wire logic        watchdogTimeout,
    input  wire logic        uninitPointerUse,
    input  wire logic        illegalOpExec,
    input  wire logic        illegalOpFlushed,
    input  wire logic        brownoutDetect,
    output logic             coreReq,
    output logic             coreIsTrap,
    output logic [5:0]       coreNumber,
    output logic [7:0]       coreVector,
    output logic [3:0]       corePriority,
    output logic             deviceReset,
    output logic             pcForceZero,
    output logic [23:0]      fetchAddress
);

    logic [53:0] flag_r;
    logic [53:0] enable_r;
    logic [2:0]  prio_r [NUM_SOURCES];
    logic        nestDis_r;
    logic [4:0]  cause_r;
    logic [7:0]  trapPend_r;
    ipta_bus_t   bus_r;
    logic [31:0] avsReadData_r;

    logic        access;
    logic        take;
    logic        wrTake;
    logic [31:0] wrMask;
    logic [31:0] rdWord;
    logic [53:0] eligible;
    logic [161:0] prioFlat;
    logic        winFound;
    logic [5:0]  winIndex;
    logic [2:0]  winPrio;
    logic [7:0]  trapIn;
    logic        lockout;
    logic        illegalHit;
    logic [4:0]  causeSet;
    logic [2:0]  trapIdx;
    logic        trapFound;

    // Bus: one wait state on every access, answer on the second edge
    assign access         = avsRead || avsWrite;
    assign take           = access && (bus_r == IPTA_BUS_DONE);
    assign wrTake         = take && avsWrite;
    assign avsWaitRequest = access && (bus_r == IPTA_BUS_IDLE);
    assign wrMask         = avsWriteData & ipta_byte_mask(avsByteEnable);
    assign avsReadData    = avsReadData_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_r <= IPTA_BUS_IDLE;
        end else begin
            unique case (bus_r)
                IPTA_BUS_IDLE: if (access) bus_r <= IPTA_BUS_DONE;
                IPTA_BUS_DONE: bus_r <= IPTA_BUS_IDLE;
            endcase
        end
    end

    always_comb begin
        rdWord = 32'h0;
        if (avsAddress >= OFS_PRIO_BASE && avsAddress <= OFS_PRIO_LAST &&
                avsAddress[1:0] == 2'b00) begin
            for (int j = 0; j < 8; j++) begin
                int s;
                s = 8 * int'((avsAddress - OFS_PRIO_BASE) >> 2) + j;
                if (s < NUM_SOURCES)
                    rdWord[4*j +: 3] = prio_r[s];
            end
        end else begin
            unique case (avsAddress)
                OFS_FLAG_LO:   rdWord = flag_r[31:0];
                OFS_FLAG_HI:   rdWord = {10'h000, flag_r[53:32]};
                OFS_ENABLE_LO: rdWord = enable_r[31:0];
                OFS_ENABLE_HI: rdWord = {10'h000, enable_r[53:32]};
                OFS_CONTROL:   rdWord = {31'h0, nestDis_r};
                OFS_STATUS:    rdWord = {12'h000, trapPend_r, 1'b0, winFound,
                                         winPrio, 1'b0, winIndex};
                OFS_CAUSE:     rdWord = {27'h0, cause_r};
                default:       rdWord = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            avsReadData_r <= 32'h0;
        else if (avsRead && bus_r == IPTA_BUS_IDLE)
            avsReadData_r <= rdWord;
    end

    // Flags: hardware set wins over a software write-one clear
    always_ff @(posedge clk_sys) begin
        logic [53:0] clr;
        clr = 54'h0;
        if (wrTake && avsAddress == OFS_FLAG_LO)
            clr[31:0] = wrMask;
        if (wrTake && avsAddress == OFS_FLAG_HI)
            clr[53:32] = wrMask[21:0];
        if (rst)
            flag_r <= FLAG_RESET;
        else
            flag_r <= ((flag_r & ~clr) | srcEvent) & IMPLEMENTED_MASK;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable_r <= EN_RESET;
        end else if (wrTake && avsAddress == OFS_ENABLE_LO) begin
            enable_r[31:0] <= ipta_merge(enable_r[31:0], avsWriteData,
                                         avsByteEnable) & IMPLEMENTED_MASK[31:0];
        end else if (wrTake && avsAddress == OFS_ENABLE_HI) begin
            enable_r[53:32] <= 22'(ipta_merge({10'h000, enable_r[53:32]},
                                              avsWriteData, avsByteEnable)
                                   & {10'h000, IMPLEMENTED_MASK[53:32]});
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int s = 0; s < NUM_SOURCES; s++)
                prio_r[s] <= PRIO_RESET;
        end else if (wrTake && avsAddress >= OFS_PRIO_BASE &&
                     avsAddress <= OFS_PRIO_LAST) begin
            for (int j = 0; j < 8; j++) begin
                int s;
                s = 8 * int'((avsAddress - OFS_PRIO_BASE) >> 2) + j;
                if (s < NUM_SOURCES && avsByteEnable[j / 2])
                    prio_r[s] <= avsWriteData[4*j +: 3];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            nestDis_r <= 1'b0;
        else if (wrTake && avsAddress == OFS_CONTROL && avsByteEnable[0])
            nestDis_r <= avsWriteData[CTRL_NEST_DIS];
    end

    // Interrupt arbitration; level 7 or any trap level blocks all sources
    always_comb begin
        for (int s = 0; s < NUM_SOURCES; s++) begin
            prioFlat[3*s +: 3] = prio_r[s];
            eligible[s] = flag_r[s] && enable_r[s] &&
                          prio_r[s] != 3'h0 &&
                          {1'b0, prio_r[s]} > cpuLevel &&
                          !(nestDis_r && inService);
        end
    end

    ipta_pick #(
        .N (NUM_SOURCES)
    ) u_pick (
        .eligible (eligible),
        .prioFlat (prioFlat),
        .found    (winFound),
        .index    (winIndex),
        .prio     (winPrio)
    );

    // Traps: non-maskable, highest pending level wins, nesting allowed
    always_comb begin
        trapIn = trapEvent;
        trapIn[ADDR_TRAP] = trapEvent[ADDR_TRAP] | trapVectorInvalid;
        trapFound = |trapPend_r;
        trapIdx = 3'h0;
        for (int t = 0; t < NUM_TRAPS; t++)
            if (trapPend_r[t])
                trapIdx = 3'(t);
    end

    assign lockout = $countones(trapIn) > 1;

    always_ff @(posedge clk_sys) begin
        logic [7:0] clr;
        clr = 8'h00;
        if (trapAck && coreReq && coreIsTrap)
            clr[coreVector[2:0]] = 1'b1;
        if (rst || lockout)
            trapPend_r <= 8'h00;
        else
            trapPend_r <= (trapPend_r & ~clr) | trapIn;
    end

    // Presented winner; a trap waits for the instruction boundary
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            coreReq      <= 1'b0;
            coreIsTrap   <= 1'b0;
            coreNumber   <= 6'h00;
            coreVector   <= 8'h00;
            corePriority <= 4'h0;
        end else if (trapFound && instrDone && !lockout) begin
            coreReq      <= 1'b1;
            coreIsTrap   <= 1'b1;
            coreNumber   <= 6'h00;
            coreVector   <= {5'h00, trapIdx};
            corePriority <= TRAP_BASE | {1'b0, trapIdx};
        end else begin
            coreReq      <= winFound;
            coreIsTrap   <= 1'b0;
            coreNumber   <= winIndex;
            coreVector   <= {2'b00, winIndex} + VECTOR_BASE;
            corePriority <= {1'b0, winPrio};
        end
    end

    // Reset sources; illegal opcode counts only if it reached execution
    assign illegalHit = illegalOpExec && !illegalOpFlushed;
    always_comb begin
        causeSet = 5'h00;
        causeSet[CAUSE_WATCHDOG] = watchdogTimeout;
        causeSet[CAUSE_UNINIT]   = uninitPointerUse;
        causeSet[CAUSE_ILLEGAL]  = illegalHit;
        causeSet[CAUSE_BROWNOUT] = brownoutDetect;
        causeSet[CAUSE_LOCKOUT]  = lockout;
    end

    always_ff @(posedge clk_sys) begin
        logic [4:0] clr;
        clr = 5'h00;
        if (wrTake && avsAddress == OFS_CAUSE)
            clr = wrMask[4:0];
        if (rst)
            cause_r <= CAUSE_RESET;
        else
            cause_r <= (cause_r & ~clr) | causeSet;
    end

    // Any reset cause drives deviceReset and pcForceZero one cycle later; the core restarts at zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            deviceReset <= 1'b0;
            pcForceZero <= 1'b1;
        end else begin
            deviceReset <= |causeSet;
            pcForceZero <= |causeSet;
        end
    end

    assign fetchAddress = RESET_ADDRESS;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_readPrio;
        avsRead && !avsWaitRequest &&
        avsAddress >= OFS_PRIO_BASE && avsAddress <= OFS_PRIO_LAST;
    endsequence

    sequence s_twoTraps;
        $countones(trapEvent) > 1;
    endsequence

    sequence s_flushedOnly;
        illegalOpExec && illegalOpFlushed && !watchdogTimeout &&
        !uninitPointerUse && !brownoutDetect && !lockout;
    endsequence

    property p_prioMsbZero;
        s_readPrio |-> avsReadData[3] == 1'b0 && avsReadData[31] == 1'b0;
    endproperty
    a_prioMsbZero: assert property (p_prioMsbZero)
        else $error("priority nibble top bit read as one");

    property p_noZeroPrio;
        coreReq && !coreIsTrap |-> corePriority != 4'h0;
    endproperty
    a_noZeroPrio: assert property (p_noZeroPrio)
        else $error("priority zero source presented");

    property p_strictAbove;
        coreReq && !coreIsTrap |-> corePriority > $past(cpuLevel);
    endproperty
    a_strictAbove: assert property (p_strictAbove)
        else $error("interrupt not above processor level");

    property p_vectorMap;
        coreReq && !coreIsTrap |->
            coreVector == {2'b00, coreNumber} + VECTOR_BASE;
    endproperty
    a_vectorMap: assert property (p_vectorMap)
        else $error("vector is not number plus eight");

    property p_nestBlock;
        nestDis_r && inService |=> !(coreReq && !coreIsTrap);
    endproperty
    a_nestBlock: assert property (p_nestBlock)
        else $error("interrupt nested while nesting disabled");

    property p_trapLevel;
        coreReq && coreIsTrap |-> corePriority[3] && $past(instrDone);
    endproperty
    a_trapLevel: assert property (p_trapLevel)
        else $error("trap level or boundary wrong");

    property p_lockout;
        s_twoTraps |=> deviceReset && cause_r[CAUSE_LOCKOUT] &&
                       trapPend_r == 8'h00;
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("simultaneous traps did not lock out");

    property p_flushedIllegal;
        s_flushedOnly |=> !deviceReset;
    endproperty
    a_flushedIllegal: assert property (p_flushedIllegal)
        else $error("flushed illegal opcode caused reset");

    property p_watchdog;
        watchdogTimeout |=> deviceReset && pcForceZero &&
                            cause_r[CAUSE_WATCHDOG];
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog timeout did not reset");

    property p_flagSet;
        srcEvent[0] |=> flag_r[0];
    endproperty
    a_flagSet: assert property (p_flagSet)
        else $error("request flag not set by event");

endmodule

// *** logic/ipta_pkg.sv ***
package ipta_pkg;

    localparam int NUM_SOURCES = 54;
    localparam int NUM_TRAPS   = 8;
    localparam int PRIO_WORDS  = 7;

    // Sources that exist; every other request number is reserved
    localparam logic [53:0] IMPLEMENTED_MASK = 54'h0_0980_03ff_ffff;

    localparam logic [7:0] VECTOR_BASE    = 8'h08;
    localparam logic [3:0] TRAP_BASE      = 4'h8;
    localparam logic [3:0] CPU_LEVEL_MAX  = 4'h7;
    localparam logic [23:0] RESET_ADDRESS = 24'h000000;

    // Register byte offsets
    localparam logic [7:0] OFS_FLAG_LO   = 8'h00;
    localparam logic [7:0] OFS_FLAG_HI   = 8'h04;
    localparam logic [7:0] OFS_ENABLE_LO = 8'h08;
    localparam logic [7:0] OFS_ENABLE_HI = 8'h0c;
    localparam logic [7:0] OFS_PRIO_BASE = 8'h10;
    localparam logic [7:0] OFS_PRIO_LAST = 8'h28;
    localparam logic [7:0] OFS_CONTROL   = 8'h2c;
    localparam logic [7:0] OFS_STATUS    = 8'h30;
    localparam logic [7:0] OFS_CAUSE     = 8'h34;

    // Field positions
    localparam int CTRL_NEST_DIS   = 0;
    localparam int CAUSE_WATCHDOG  = 0;
    localparam int CAUSE_UNINIT    = 1;
    localparam int CAUSE_ILLEGAL   = 2;
    localparam int CAUSE_BROWNOUT  = 3;
    localparam int CAUSE_LOCKOUT   = 4;
    localparam int CAUSE_WIDTH     = 5;

    // Values after reset
    localparam logic [2:0]  PRIO_RESET  = 3'h4;
    localparam logic [53:0] FLAG_RESET  = 54'h0;
    localparam logic [53:0] EN_RESET    = 54'h0;
    localparam logic [4:0]  CAUSE_RESET = 5'h00;

    typedef enum logic [1:0] {
        IPTA_BUS_IDLE,
        IPTA_BUS_DONE
    } ipta_bus_t;

    // Bytewise merge for Avalon byte enables
    function automatic logic [31:0] ipta_byte_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] ipta_merge(input logic [31:0] oldVal,
                                               input logic [31:0] newVal,
                                               input logic [3:0]  be);
        logic [31:0] m;
        m = ipta_byte_mask(be);
        return (oldVal & ~m) | (newVal & m);
    endfunction

endpackage

// *** logic/ipta_pick.sv ***
module ipta_pick
    import ipta_pkg::*;
#(
    parameter int N = 54
) (
    input  wire logic [N-1:0]   eligible,
    input  wire logic [3*N-1:0] prioFlat,
    output logic                found,
    output logic [5:0]          index,
    output logic [2:0]          prio
);

    // Scanning downward with >= lets the lowest number win a tie
    always_comb begin
        found = 1'b0;
        index = 6'h00;
        prio  = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (eligible[i] && (!found || prioFlat[3*i +: 3] >= prio)) begin
                found = 1'b1;
                index = 6'(i);
                prio  = prioFlat[3*i +: 3];
            end
        end
    end

endmodule

// *** testbench/ipta_core_model.sv ***
module ipta_core_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       coreReq,
    input  wire logic       coreIsTrap,
    input  wire logic       hold,
    input  wire logic [7:0] ackDelay,
    output logic            trapAck,
    output logic            instrDone
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt;

    // Cool-down after an ack, so a trap still shown is not acked twice
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt       <= 8'h00;
            trapAck   <= 1'b0;
            instrDone <= 1'b0;
        end else begin
            instrDone <= !hold;
            trapAck   <= (cnt == 8'h04);
            if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end else if (coreReq && coreIsTrap) begin
                cnt <= ackDelay + 8'h04;
            end
        end
    end
endmodule

// *** testbench/testbench.sv ***
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module testbench
    import ipta_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 0, rst = 1, avsRead = 0, avsWrite = 0;
    logic [7:0] avsAddress = 0, trapEvent = 0, ackDelay = 8'h01;
    logic [31:0] avsWriteData = 0, d;
    logic [3:0] avsByteEnable = 4'hf, cpuLevel = 0;
    logic [53:0] srcEvent = 0;
    logic [5:0] errIn = 0;
    logic inService = 0, hold = 0;
    logic [31:0] avsReadData;
    logic avsWaitRequest, coreReq, coreIsTrap, deviceReset, pcForceZero;
    logic trapAck, instrDone;
    logic [5:0] coreNumber;
    logic [7:0] coreVector;
    logic [3:0] corePriority;
    logic [23:0] fetchAddress;
    int n_errors = 0, n_checks = 0;

    ipta_arbiter i_ipta_arbiter (.clk_sys(clk_sys), .rst(rst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .srcEvent(srcEvent), .cpuLevel(cpuLevel), .inService(inService),
        .instrDone(instrDone), .trapEvent(trapEvent),
        .trapVectorInvalid(errIn[5]), .trapAck(trapAck),
        .watchdogTimeout(errIn[0]), .uninitPointerUse(errIn[1]),
        .illegalOpExec(errIn[2]), .brownoutDetect(errIn[3]),
        .illegalOpFlushed(errIn[4]), .coreReq(coreReq),
        .coreIsTrap(coreIsTrap), .coreNumber(coreNumber),
        .coreVector(coreVector), .corePriority(corePriority),
        .deviceReset(deviceReset), .pcForceZero(pcForceZero),
        .fetchAddress(fetchAddress));

    ipta_core_model i_ipta_core_model (.clk_sys(clk_sys), .rst(rst),
        .coreReq(coreReq), .coreIsTrap(coreIsTrap), .hold(hold),
        .ackDelay(ackDelay), .trapAck(trapAck), .instrDone(instrDone));

    always #5 clk_sys = ~clk_sys;

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic timeOut();
        n_errors++;
        $display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
        print_verdict();
    endtask

    // Waitrequest is looked at on rising edges only; data is taken there
    task automatic busWait();
        int n = 0;
        do begin @(posedge clk_sys); n++; end
        while (avsWaitRequest !== 1'b0 && n < 40);
        if (avsWaitRequest !== 1'b0) timeOut();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        avsWrite <= 1'b1;
        avsAddress <= a;
        avsWriteData <= v;
        busWait();
        avsWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        avsRead <= 1'b1;
        avsAddress <= a;
        busWait();
        v = avsReadData;
        avsRead <= 1'b0;
    endtask

    task automatic chkRd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHK(v, e)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulse(input logic [53:0] s, input logic [7:0] t,
                         input logic [5:0] e);
        @(posedge clk_sys);
        srcEvent <= s;
        trapEvent <= t;
        errIn <= e;
        @(posedge clk_sys);
        srcEvent <= '0;
        trapEvent <= '0;
        errIn <= '0;
    endtask

    task automatic lvl(input logic [3:0] v);
        @(posedge clk_sys);
        cpuLevel <= v;
        tick(2);
    endtask

    task automatic waitTrap(input logic wantTrap);
        int n = 0;
        do begin tick(1); n++; end
        while ((coreReq === 1'b1 && coreIsTrap === 1'b1) != wantTrap
               && n < 80);
        if (n >= 80) timeOut();
    endtask

    // Expected number of reset cycles with the forced program counter, counted over four edges
    task automatic expectReset(input int e);
        int h = 0;
        #1;
        repeat (4) begin
            if (deviceReset === 1'b1 && pcForceZero === 1'b1) h++;
            tick(1);
        end
        `CHK(h, e)
    endtask

    task automatic endTest(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        `CHK(pcForceZero, 1'b1)
        `CHK(fetchAddress, 24'h000000)
        rst <= 1'b0;
        chkRd(OFS_PRIO_BASE, {8{1'b0, PRIO_RESET}});
        chkRd(OFS_CAUSE, 32'h0);
        chkRd(8'hfc, 32'h0);
        wr(OFS_PRIO_BASE, 32'hffffffff);
        chkRd(OFS_PRIO_BASE, 32'h77777777);
        avsByteEnable <= 4'h1;
        wr(OFS_PRIO_BASE, 32'h00000011);
        avsByteEnable <= 4'hf;
        chkRd(OFS_PRIO_BASE, 32'h77777711);
        endTest("registers");
        pulse(54'h8, 8'h0, 6'h0);
        chkRd(OFS_FLAG_LO, 32'h8);
        `CHK(coreReq, 1'b0)
        wr(OFS_ENABLE_LO, 32'hffffffff);
        wr(OFS_ENABLE_HI, 32'hffffffff);
        chkRd(OFS_ENABLE_HI, {10'h0, IMPLEMENTED_MASK[53:32]});
        tick(2);
        `CHK({coreReq, coreNumber, coreVector}, {1'b1, 6'd3, 8'd11})
        `CHK(corePriority, 4'h7)
        wr(OFS_FLAG_LO, 32'h8);
        for (int i = 0; i < 54; i++) begin
            pulse(54'h1 << i, 8'h0, 6'h0);
            tick(2);
            `CHK(coreReq, IMPLEMENTED_MASK[i])
            if (IMPLEMENTED_MASK[i]) `CHK(coreVector, 8'(i + 8))
            wr(i < 32 ? OFS_FLAG_LO : OFS_FLAG_HI, 32'h1 << (i % 32));
        end
        pulse('1, 8'h0, 6'h0);
        chkRd(OFS_FLAG_LO, IMPLEMENTED_MASK[31:0]);
        chkRd(OFS_FLAG_HI, {10'h0, IMPLEMENTED_MASK[53:32]});
        wr(OFS_FLAG_LO, '1);
        wr(OFS_FLAG_HI, '1);
        endTest("sources");
        wr(OFS_PRIO_BASE, 32'h00100010);
        pulse(54'h22, 8'h0, 6'h0);
        tick(2);
        `CHK(coreNumber, 6'd1)
        wr(OFS_PRIO_BASE, 32'h00200010);
        tick(2);
        `CHK({coreNumber, corePriority}, {6'd5, 4'h2})
        chkRd(OFS_STATUS, 32'h00000505);
        lvl(4'h2);
        `CHK(coreReq, 1'b0)
        lvl(4'h1);
        `CHK(coreNumber, 6'd5)
        lvl(4'h7);
        `CHK(coreReq, 1'b0)
        lvl(4'h0);
        wr(OFS_PRIO_BASE, 32'h00000010);
        tick(2);
        `CHK(coreNumber, 6'd1)
        @(posedge clk_sys);
        inService <= 1'b1;
        wr(OFS_CONTROL, 32'h1);
        tick(2);
        `CHK(coreReq, 1'b0)
        wr(OFS_CONTROL, 32'h0);
        tick(2);
        `CHK(coreReq, 1'b1)
        @(posedge clk_sys);
        inService <= 1'b0;
        wr(OFS_FLAG_LO, '1);
        endTest("arbitration");
        wr(OFS_ENABLE_LO, 32'h0);
        lvl(4'h7);
        hold <= 1'b1;
        pulse(54'h0, 8'h08, 6'h0);
        tick(4);
        `CHK(coreReq, 1'b0)
        hold <= 1'b0;
        waitTrap(1'b1);
        `CHK({coreVector, corePriority}, {8'h03, 4'hb})
        waitTrap(1'b0);
        pulse(54'h0, 8'h00, 6'h20);
        waitTrap(1'b1);
        `CHK({coreVector, corePriority}, {8'h04, 4'hc})
        waitTrap(1'b0);
        ackDelay <= 8'h14;
        pulse(54'h0, 8'h04, 6'h0);
        waitTrap(1'b1);
        pulse(54'h0, 8'h20, 6'h0);
        tick(3);
        `CHK({coreVector, corePriority}, {8'h05, 4'hd})
        waitTrap(1'b0);
        ackDelay <= 8'h01;
        endTest("traps");
        pulse(54'h0, 8'h05, 6'h0);
        expectReset(1);
        `CHK(coreReq, 1'b0)
        chkRd(OFS_CAUSE, 32'h10);
        wr(OFS_CAUSE, 32'h1f);
        for (int i = 0; i < 5; i++) begin
            pulse(54'h0, 8'h0, i < 4 ? 6'h1 << i : 6'h14);
            expectReset(i < 4);
            chkRd(OFS_CAUSE, i < 4 ? 32'h1 << i : 32'h0);
            wr(OFS_CAUSE, 32'h1f);
        end
        endTest("resets");
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        timeOut();
    end
endmodule
